// ### ppm_board.sv
// Purpose: Board-side circuitry seen at the bidirectional port pins
// Assumes: The board drives a pin only where drv_en is high, never against the device
// Notes: A pin that nobody drives and that has no pull-up shows the inverse of its
//    last level, so a floating input never reads as a steady value
`timescale 1ns/1ns
module ppm_board #(
   parameter int W = 8
) (
   input wire logic clock,
   input wire logic [W-1:0] pin_o,
   input wire logic [W-1:0] pin_oe,
   input wire logic [W-1:0] pin_pu,
   input wire logic [W-1:0] drv,
   input wire logic [W-1:0] drv_en,
   output logic [W-1:0] pin_i
);
   logic [W-1:0] last_reg = '0;
   logic [W-1:0] free_w;

   // Pins that neither party drives
   assign free_w = ~pin_oe & ~drv_en;
   // Device first, then board, then pull-up, else a changing float
   assign pin_i = (pin_oe & pin_o) | (~pin_oe & drv_en & drv) | (free_w & pin_pu)
      | (free_w & ~pin_pu & ~last_reg);

   // Remember each level so an undriven pin keeps toggling
   always_ff @(posedge clock)
      last_reg <= pin_i;
endmodule

// ### ppm_pkg.sv
// Purpose: Constants for the port and pin-function multiplexer
// Assumes: 32-bit APB, one register per aligned word
// Notes: Data registers read back pin level for input bits
package ppm_pkg;
   // Port widths
   localparam int P0_W = 4;
   localparam int P1_W = 5;
   localparam int P3_W = 4;
   localparam int P6_W = 6;
   localparam int SEG_W = 28;
   localparam int MTR_W = 16;
   localparam int IRQ_N = 3;
   // Register byte offsets
   localparam logic [7:0] A_P0_DAT = 8'h00;
   localparam logic [7:0] A_P0_DIR = 8'h04;
   localparam logic [7:0] A_P0_PU = 8'h08;
   localparam logic [7:0] A_P0_CTL = 8'h0c;
   localparam logic [7:0] A_EDGE = 8'h10;
   localparam logic [7:0] A_P1_DAT = 8'h14;
   localparam logic [7:0] A_P1_CTL = 8'h18;
   localparam logic [7:0] A_P2_DAT = 8'h1c;
   localparam logic [7:0] A_P2_CTL = 8'h20;
   localparam logic [7:0] A_P3_DAT = 8'h24;
   localparam logic [7:0] A_P3_DIR = 8'h28;
   localparam logic [7:0] A_P3_CTL = 8'h2c;
   localparam logic [7:0] A_P4_DAT = 8'h30;
   localparam logic [7:0] A_P4_DIR = 8'h34;
   localparam logic [7:0] A_P4_CTL = 8'h38;
   localparam logic [7:0] A_P5_DAT = 8'h3c;
   localparam logic [7:0] A_P5_CTL = 8'h40;
   localparam logic [7:0] A_P6_DAT = 8'h44;
   localparam logic [7:0] A_P6_DIR = 8'h48;
   localparam logic [7:0] A_P6_CTL = 8'h4c;
   localparam logic [7:0] A_P8_DAT = 8'h50;
   localparam logic [7:0] A_P8_DIR = 8'h54;
   localparam logic [7:0] A_P8_CTL = 8'h58;
   localparam logic [7:0] A_P9_DAT = 8'h5c;
   localparam logic [7:0] A_P9_DIR = 8'h60;
   localparam logic [7:0] A_P9_CTL = 8'h64;
   localparam logic [7:0] A_SEG_SEL = 8'h68;
   localparam logic [7:0] A_LCD_CFG = 8'h6c;
   // Field positions
   localparam int EDGE_RISE_BIT = 0;
   localparam int EDGE_FALL_BIT = 1;
   localparam int SEGSEL_P9_LSB = 4;
   localparam int LCD_DIV4_BIT = 0;
   localparam int LCD_BIAS3_BIT = 1;
   // Reset value of every control and latch register
   localparam logic [7:0] RST_VAL = 8'h00;
endpackage

// ### ppm_top.sv
// What this block does
// - The 4-bit port 0 sets each pin to input or output by its own direction bit.
// - A port 0 pin used as input gets a pull-up when its pull-up option bit asks for it.
// - Each external interrupt input detects rising, falling or both edges as programmed.
// - Each bit of the 5-bit input port 1 can become an analog input instead of a digital one.
// - In control mode the 8-bit output port 2 drives meter 1 and 2 PWM outputs instead of its latch.
// - The 4-bit port 3 picks port or alternate function and direction per bit.
// - Port 4 becomes LCD segments 0 to 7 as a whole byte in segment control mode.
// - In control mode the 8-bit output port 5 drives meter 3 and 4 PWM outputs.
// - The 6-bit port 6 picks per bit among port use and its timer, clock, sound and async serial lines.
// - Port 8 has per-bit direction and in control mode carries LCD segments 8 to 15.
// - Port 9 has its own direction and offers timer, sync serial and LCD segments 16 to 23.
// - The LCD common outputs drive only in four-time division at one-third bias.
// - The block is held in reset while resetn is low and runs while it is high.
// Purpose: Pin multiplexer between port latches and peripheral functions
// Assumes: Pin inputs synchronous to clock, APB slave with one wait state
// Notes: Pin outputs lag register writes by one clock
`timescale 1ns/1ns
module ppm_top #(
   parameter int ADDR_W = 8
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic [3:0] p0_i,
   output logic [3:0] p0_o,
   output logic [3:0] p0_oe,
   output logic [3:0] p0_pu,
   output logic [3:0] p0_alt_i,
   output logic [2:0] ext_irq_event,
   input wire logic [4:0] p1_i,
   output logic [4:0] analog_in_sel,
   output logic [7:0] p2_o,
   input wire logic [3:0] p3_i,
   output logic [3:0] p3_o,
   output logic [3:0] p3_oe,
   input wire logic [3:0] p3_alt_o,
   input wire logic [3:0] p3_alt_oe,
   output logic [3:0] p3_alt_i,
   input wire logic [7:0] p4_i,
   output logic [7:0] p4_o,
   output logic [7:0] p4_oe,
   output logic [7:0] p5_o,
   input wire logic [5:0] p6_i,
   output logic [5:0] p6_o,
   output logic [5:0] p6_oe,
   input wire logic [5:0] p6_alt_o,
   input wire logic [5:0] p6_alt_oe,
   output logic [5:0] p6_alt_i,
   input wire logic [7:0] p8_i,
   output logic [7:0] p8_o,
   output logic [7:0] p8_oe,
   input wire logic [7:0] p9_i,
   output logic [7:0] p9_o,
   output logic [7:0] p9_oe,
   input wire logic [7:0] p9_alt_o,
   input wire logic [7:0] p9_alt_oe,
   output logic [7:0] p9_alt_i,
   input wire logic [15:0] meter_pwm,
   input wire logic [27:0] lcd_seg,
   input wire logic [3:0] lcd_common_in,
   output logic [3:0] lcd_common_out
);
   // Refuse address widths that cannot reach the whole register map
   if (ADDR_W < 7 || ADDR_W > 32)
   begin : g_bad_addr_w
      $error("ppm_top: ADDR_W must hold the register map");
   end

   typedef struct packed {
      logic [3:0] p0_lat, p0_dir, p0_pull, p0_ctl, p0_prev;
      logic [5:0] edge_sel;
      logic [4:0] p1_ctl;
      logic [7:0] p2_lat, p2_ctl;
      logic [3:0] p3_lat, p3_dir, p3_ctl, p3_seg;
      logic [7:0] p4_lat, p4_dir;
      logic p4_ctl;
      logic [7:0] p5_lat, p5_ctl;
      logic [5:0] p6_lat, p6_dir, p6_ctl;
      logic [7:0] p8_lat, p8_dir;
      logic p8_ctl;
      logic [7:0] p9_lat, p9_dir, p9_ctl, p9_seg;
      logic [1:0] lcd_cfg;
      logic [3:0] p0_o, p0_oe, p0_pu, p0_alt;
      logic [2:0] irq;
      logic [7:0] p2_o, p4_o, p4_oe, p5_o, p8_o, p8_oe, p9_o, p9_oe, p9_alt;
      logic [3:0] p3_o, p3_oe, p3_alt, com;
      logic [5:0] p6_o, p6_oe, p6_alt;
      logic rdy, err;
      logic [31:0] rdata;
   } ppm_state_t;

   ppm_state_t s_reg;
   ppm_state_t s_next;

   // Per-bit choice between alternate and latch value
   function automatic logic [7:0] ppm_pick(input logic [7:0] sel, input logic [7:0] alt, input logic [7:0] lat);
      ppm_pick = (sel & alt) | (~sel & lat);
   endfunction

   // Reverse a byte; several ports number their segments downwards
   function automatic logic [7:0] ppm_rev(input logic [7:0] v);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 8; i++)
         r[i] = v[7-i];
      ppm_rev = r;
   endfunction

   // Bus decode helpers and segment orderings
   logic [7:0] a;
   logic wr_en;
   logic [7:0] wd;
   logic [3:0] seg3;
   logic [7:0] seg9;
   assign a = 8'(paddr);
   assign wd = pwdata[7:0];
   // Write lands on the edge where the master sees pready high
   assign wr_en = psel & penable & pwrite & s_reg.rdy;
   // Segments 24..27 sit on bits 3..0, segments 16..23 on bits 7..0 reversed
   assign seg3 = 4'(ppm_rev(lcd_seg[27:20]));
   assign seg9 = ppm_rev(lcd_seg[23:16]);

   always_comb
   begin
      logic [3:0] rise, fall;
      logic [31:0] rd;
      logic hit;
      s_next = s_reg;
      rd = 32'h0;
      hit = 1'b1;
      // Edge detection on port 0 interrupt inputs
      rise = p0_i & ~s_reg.p0_prev;
      fall = ~p0_i & s_reg.p0_prev;
      s_next.p0_prev = p0_i;
      for (int i = 0; i < ppm_pkg::IRQ_N; i++)
         s_next.irq[i] = s_reg.p0_ctl[i] & ((rise[i] & s_reg.edge_sel[2*i+ppm_pkg::EDGE_RISE_BIT])
            | (fall[i] & s_reg.edge_sel[2*i+ppm_pkg::EDGE_FALL_BIT]));
      // Port 0: control mode is input-only, so it releases the pin
      s_next.p0_o = s_reg.p0_lat;
      s_next.p0_oe = s_reg.p0_dir & ~s_reg.p0_ctl;
      s_next.p0_pu = s_reg.p0_pull & ~s_next.p0_oe;
      s_next.p0_alt = p0_i & s_reg.p0_ctl;
      // Output-only meter ports
      s_next.p2_o = ppm_pick(s_reg.p2_ctl, meter_pwm[7:0], s_reg.p2_lat);
      s_next.p5_o = ppm_pick(s_reg.p5_ctl, meter_pwm[15:8], s_reg.p5_lat);
      // Port 3: segment, peripheral or latch per bit
      s_next.p3_o = 4'(ppm_pick({4'h0, s_reg.p3_ctl},
         {4'h0, (s_reg.p3_seg & seg3) | (~s_reg.p3_seg & p3_alt_o)}, {4'h0, s_reg.p3_lat}));
      s_next.p3_oe = 4'(ppm_pick({4'h0, s_reg.p3_ctl},
         {4'h0, s_reg.p3_seg | p3_alt_oe}, {4'h0, s_reg.p3_dir}));
      s_next.p3_alt = p3_i & s_reg.p3_ctl & ~s_reg.p3_seg;
      // Ports 4 and 8 switch to segments as a whole byte
      s_next.p4_o = s_reg.p4_ctl ? ppm_rev(lcd_seg[7:0]) : s_reg.p4_lat;
      s_next.p4_oe = s_reg.p4_ctl ? 8'hff : s_reg.p4_dir;
      s_next.p8_o = s_reg.p8_ctl ? lcd_seg[15:8] : s_reg.p8_lat;
      s_next.p8_oe = s_reg.p8_ctl ? 8'hff : s_reg.p8_dir;
      // Port 6: timer, clock, sound and async serial lines
      s_next.p6_o = 6'(ppm_pick({2'h0, s_reg.p6_ctl}, {2'h0, p6_alt_o}, {2'h0, s_reg.p6_lat}));
      s_next.p6_oe = 6'(ppm_pick({2'h0, s_reg.p6_ctl}, {2'h0, p6_alt_oe}, {2'h0, s_reg.p6_dir}));
      s_next.p6_alt = p6_i & s_reg.p6_ctl;
      // Port 9: timers, sync serial or segments 16..23
      s_next.p9_o = ppm_pick(s_reg.p9_ctl, (s_reg.p9_seg & seg9) | (~s_reg.p9_seg & p9_alt_o), s_reg.p9_lat);
      s_next.p9_oe = ppm_pick(s_reg.p9_ctl, s_reg.p9_seg | p9_alt_oe, s_reg.p9_dir);
      s_next.p9_alt = p9_i & s_reg.p9_ctl & ~s_reg.p9_seg;
      // Commons held low unless four-time division at one-third bias
      s_next.com = (s_reg.lcd_cfg[ppm_pkg::LCD_DIV4_BIT] & s_reg.lcd_cfg[ppm_pkg::LCD_BIAS3_BIT])
         ? lcd_common_in : 4'h0;
      // Read mux: data offsets show pin level for inputs, latch for outputs
      unique case (a)
         ppm_pkg::A_P0_DAT: rd[3:0] = 4'(ppm_pick({4'h0, s_reg.p0_dir}, {4'h0, s_reg.p0_lat}, {4'h0, p0_i}));
         ppm_pkg::A_P0_DIR: rd[3:0] = s_reg.p0_dir;
         ppm_pkg::A_P0_PU: rd[3:0] = s_reg.p0_pull;
         ppm_pkg::A_P0_CTL: rd[3:0] = s_reg.p0_ctl;
         ppm_pkg::A_EDGE: rd[5:0] = s_reg.edge_sel;
         ppm_pkg::A_P1_DAT: rd[4:0] = p1_i & ~s_reg.p1_ctl;
         ppm_pkg::A_P1_CTL: rd[4:0] = s_reg.p1_ctl;
         ppm_pkg::A_P2_DAT: rd[7:0] = s_reg.p2_lat;
         ppm_pkg::A_P2_CTL: rd[7:0] = s_reg.p2_ctl;
         ppm_pkg::A_P3_DAT: rd[3:0] = 4'(ppm_pick({4'h0, s_reg.p3_dir}, {4'h0, s_reg.p3_lat}, {4'h0, p3_i}));
         ppm_pkg::A_P3_DIR: rd[3:0] = s_reg.p3_dir;
         ppm_pkg::A_P3_CTL: rd[3:0] = s_reg.p3_ctl;
         ppm_pkg::A_P4_DAT: rd[7:0] = ppm_pick(s_reg.p4_dir, s_reg.p4_lat, p4_i);
         ppm_pkg::A_P4_DIR: rd[7:0] = s_reg.p4_dir;
         ppm_pkg::A_P4_CTL: rd[0] = s_reg.p4_ctl;
         ppm_pkg::A_P5_DAT: rd[7:0] = s_reg.p5_lat;
         ppm_pkg::A_P5_CTL: rd[7:0] = s_reg.p5_ctl;
         ppm_pkg::A_P6_DAT: rd[5:0] = 6'(ppm_pick({2'h0, s_reg.p6_dir}, {2'h0, s_reg.p6_lat}, {2'h0, p6_i}));
         ppm_pkg::A_P6_DIR: rd[5:0] = s_reg.p6_dir;
         ppm_pkg::A_P6_CTL: rd[5:0] = s_reg.p6_ctl;
         ppm_pkg::A_P8_DAT: rd[7:0] = ppm_pick(s_reg.p8_dir, s_reg.p8_lat, p8_i);
         ppm_pkg::A_P8_DIR: rd[7:0] = s_reg.p8_dir;
         ppm_pkg::A_P8_CTL: rd[0] = s_reg.p8_ctl;
         ppm_pkg::A_P9_DAT: rd[7:0] = ppm_pick(s_reg.p9_dir, s_reg.p9_lat, p9_i);
         ppm_pkg::A_P9_DIR: rd[7:0] = s_reg.p9_dir;
         ppm_pkg::A_P9_CTL: rd[7:0] = s_reg.p9_ctl;
         ppm_pkg::A_SEG_SEL: rd[11:0] = {s_reg.p9_seg, s_reg.p3_seg};
         ppm_pkg::A_LCD_CFG: rd[1:0] = s_reg.lcd_cfg;
         default: hit = 1'b0;
      endcase
      // One wait state: answer is prepared in the first access cycle
      s_next.rdy = psel & penable & ~s_reg.rdy;
      // A shift rather than a part-select keeps the high-bit test legal for every ADDR_W
      s_next.err = s_next.rdy & ~(hit && (paddr >> 8) == '0);
      s_next.rdata = (s_next.rdy & ~pwrite & ~s_next.err) ? rd : 32'h0;
      // Register writes; software sets serial direction and latch itself
      if (wr_en && !s_reg.err)
      begin
         unique case (a)
            ppm_pkg::A_P0_DAT: s_next.p0_lat = wd[3:0];
            ppm_pkg::A_P0_DIR: s_next.p0_dir = wd[3:0];
            ppm_pkg::A_P0_PU: s_next.p0_pull = wd[3:0];
            ppm_pkg::A_P0_CTL: s_next.p0_ctl = wd[3:0];
            ppm_pkg::A_EDGE: s_next.edge_sel = wd[5:0];
            ppm_pkg::A_P1_CTL: s_next.p1_ctl = wd[4:0];
            ppm_pkg::A_P2_DAT: s_next.p2_lat = wd;
            ppm_pkg::A_P2_CTL: s_next.p2_ctl = wd;
            ppm_pkg::A_P3_DAT: s_next.p3_lat = wd[3:0];
            ppm_pkg::A_P3_DIR: s_next.p3_dir = wd[3:0];
            ppm_pkg::A_P3_CTL: s_next.p3_ctl = wd[3:0];
            ppm_pkg::A_P4_DAT: s_next.p4_lat = wd;
            ppm_pkg::A_P4_DIR: s_next.p4_dir = wd;
            ppm_pkg::A_P4_CTL: s_next.p4_ctl = wd[0];
            ppm_pkg::A_P5_DAT: s_next.p5_lat = wd;
            ppm_pkg::A_P5_CTL: s_next.p5_ctl = wd;
            ppm_pkg::A_P6_DAT: s_next.p6_lat = wd[5:0];
            ppm_pkg::A_P6_DIR: s_next.p6_dir = wd[5:0];
            ppm_pkg::A_P6_CTL: s_next.p6_ctl = wd[5:0];
            ppm_pkg::A_P8_DAT: s_next.p8_lat = wd;
            ppm_pkg::A_P8_DIR: s_next.p8_dir = wd;
            ppm_pkg::A_P8_CTL: s_next.p8_ctl = wd[0];
            ppm_pkg::A_P9_DAT: s_next.p9_lat = wd;
            ppm_pkg::A_P9_DIR: s_next.p9_dir = wd;
            ppm_pkg::A_P9_CTL: s_next.p9_ctl = wd;
            ppm_pkg::A_SEG_SEL: {s_next.p9_seg, s_next.p3_seg} = pwdata[11:0];
            ppm_pkg::A_LCD_CFG: s_next.lcd_cfg = pwdata[1:0];
            default: s_next.rdata = s_next.rdata;
         endcase
      end
   end

   // Whole state clears while resetn is low
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   // Every output straight from the state register
   assign pready = s_reg.rdy;
   assign prdata = s_reg.rdata;
   assign pslverr = s_reg.err;
   assign p0_o = s_reg.p0_o;
   assign p0_oe = s_reg.p0_oe;
   assign p0_pu = s_reg.p0_pu;
   assign p0_alt_i = s_reg.p0_alt;
   assign ext_irq_event = s_reg.irq;
   assign analog_in_sel = s_reg.p1_ctl;
   assign p2_o = s_reg.p2_o;
   assign p3_o = s_reg.p3_o;
   assign p3_oe = s_reg.p3_oe;
   assign p3_alt_i = s_reg.p3_alt;
   assign p4_o = s_reg.p4_o;
   assign p4_oe = s_reg.p4_oe;
   assign p5_o = s_reg.p5_o;
   assign p6_o = s_reg.p6_o;
   assign p6_oe = s_reg.p6_oe;
   assign p6_alt_i = s_reg.p6_alt;
   assign p8_o = s_reg.p8_o;
   assign p8_oe = s_reg.p8_oe;
   assign p9_o = s_reg.p9_o;
   assign p9_oe = s_reg.p9_oe;
   assign p9_alt_i = s_reg.p9_alt;
   assign lcd_common_out = s_reg.com;

   // Checks on the multiplexer behaviour
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   p0_dir_a: assert property (##1 p0_oe == $past(s_reg.p0_dir & ~s_reg.p0_ctl))
      else $error("port 0 enable does not follow direction");
   pull_gate_a: assert property (p0_pu != 4'h0 |-> (p0_pu & p0_oe) == 4'h0)
      else $error("pull-up on a driven pin");
   irq_rise_a: assert property (s_reg.p0_ctl[0] && s_reg.edge_sel[0] && !s_reg.p0_prev[0] && p0_i[0]
      |=> ext_irq_event[0])
      else $error("rising edge missed");
   irq_fall_a: assert property (s_reg.p0_ctl[1] && s_reg.edge_sel[3] && s_reg.p0_prev[1] && !p0_i[1]
      |=> ext_irq_event[1])
      else $error("falling edge missed");
   irq_off_a: assert property (s_reg.edge_sel[1:0] == 2'h0 |=> !ext_irq_event[0])
      else $error("event with no edge enabled");
   ana_read_a: assert property (psel && penable && !s_reg.rdy && !pwrite && paddr == ppm_pkg::A_P1_DAT
      |=> (prdata[4:0] & $past(s_reg.p1_ctl)) == 5'h0 && prdata[31:5] == 27'h0)
      else $error("analog pin read as digital");
   meter_out_a: assert property (s_reg.p2_ctl == 8'hff && s_reg.p5_ctl == 8'hff
      |=> p2_o == $past(meter_pwm[7:0]) && p5_o == $past(meter_pwm[15:8]))
      else $error("meter output not routed");
   seg_byte_a: assert property (s_reg.p4_ctl && s_reg.p8_ctl |=> p4_oe == 8'hff && p8_oe == 8'hff)
      else $error("segment port not driven");
   com_gate_a: assert property (!(s_reg.lcd_cfg[0] && s_reg.lcd_cfg[1]) |=> lcd_common_out == 4'h0)
      else $error("commons driven outside 1/3 bias mode");
   ctl_owner_a: assert property (s_reg.p6_ctl != 6'h0
      |=> ((p6_oe ^ $past(p6_alt_oe)) & $past(s_reg.p6_ctl)) == 6'h0)
      else $error("latch drives a control pin");

   // Segment routing and port-mode fallbacks; reversed segment orders checked at both end bits
   p3_owner_a: assert property (s_reg.p3_ctl != 4'h0
      |=> ((p3_oe ^ $past(s_reg.p3_seg | p3_alt_oe)) & $past(s_reg.p3_ctl)) == 4'h0)
      else $error("port 3 enable not taken from its function");
   p3_seg_a: assert property ((s_reg.p3_ctl & s_reg.p3_seg) == 4'hf
      |=> p3_o[0] == $past(lcd_seg[27]) && p3_o[3] == $past(lcd_seg[24]))
      else $error("port 3 segment order wrong");
   p4_seg_a: assert property (s_reg.p4_ctl
      |=> p4_o[0] == $past(lcd_seg[7]) && p4_o[7] == $past(lcd_seg[0]))
      else $error("port 4 segment order wrong");
   p8_seg_a: assert property (s_reg.p8_ctl |=> p8_o == $past(lcd_seg[15:8]))
      else $error("port 8 segments not routed");
   p9_seg_a: assert property ((s_reg.p9_ctl & s_reg.p9_seg) == 8'hff
      |=> p9_o[0] == $past(lcd_seg[23]) && p9_o[7] == $past(lcd_seg[16]))
      else $error("port 9 segment order wrong");
   p5_latch_a: assert property (s_reg.p5_ctl == 8'h00 |=> p5_o == $past(s_reg.p5_lat))
      else $error("port 5 latch not on its pins");
   p6_latch_a: assert property (s_reg.p6_ctl == 6'h00
      |=> p6_o == $past(s_reg.p6_lat) && p6_oe == $past(s_reg.p6_dir))
      else $error("port 6 latch not on its pins");
   apb_wait_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
      else $error("answer not one cycle wide");

   irq_seen_c: cover property (ext_irq_event != 3'h0);
   seg_mode_c: cover property (s_reg.p4_ctl && s_reg.p9_seg != 8'h00);
   com_on_c: cover property (lcd_common_out != 4'h0);
   p3_seg_c: cover property (s_reg.p3_ctl != 4'h0 && s_reg.p3_seg != 4'h0);
   ana_sel_c: cover property (analog_in_sel != 5'h0);
endmodule

// ### ppm_top_tb.sv
// Purpose: Self-checking bench for the port and pin-function multiplexer
// Assumes: APB slave answers within a bounded wait; pin outputs lag writes by one clock
// Notes: All bidirectional pins share one board model; only port 0 is driven by the board
`timescale 1ns/1ns
module ppm_top_tb;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rv;
   logic pready, pslverr, ev;
   logic [3:0] p0_i, p0_o, p0_oe, p0_pu, p0_alt_i, p3_i, p3_o, p3_oe, p3_alt_i, lcd_common_out, e3;
   logic [3:0] p0_drv = 4'h0, p0_den = 4'h0, p3_alt_o = 4'h9, p3_alt_oe = 4'hc, lcd_common_in = 4'h6;
   logic [2:0] ext_irq_event;
   logic [4:0] p1_i = 5'h1f, analog_in_sel;
   logic [5:0] p6_i, p6_o, p6_oe, p6_alt_i, p6_alt_o = 6'h2d, p6_alt_oe = 6'h33;
   logic [7:0] p2_o, p5_o, p4_i, p4_o, p4_oe, p8_i, p8_o, p8_oe, p9_i, p9_o, p9_oe, p9_alt_i, e4, e9;
   logic [7:0] p9_alt_o = 8'h96, p9_alt_oe = 8'h5a;
   logic [15:0] meter_pwm = 16'ha53c;
   logic [27:0] lcd_seg = 28'h5a3c1e7;
   int errors = 0, n_compared = 0, n_irq = 0, sel = 0;

   always #50 clock = ~clock;

   ppm_top u_dut (.*);

   // One board model spans every bidirectional port
   ppm_board #(.W(38)) u_board (
      .clock(clock),
      .pin_o({p9_o, p8_o, p6_o, p4_o, p3_o, p0_o}),
      .pin_oe({p9_oe, p8_oe, p6_oe, p4_oe, p3_oe, p0_oe}),
      .pin_pu({34'h0, p0_pu}),
      .drv({34'h0, p0_drv}),
      .drv_en({34'h0, p0_den}),
      .pin_i({p9_i, p8_i, p6_i, p4_i, p3_i, p0_i})
   );

   // Count cycles in which the watched interrupt event is high
   always @(posedge clock)
      if (ext_irq_event[sel] === 1'b1)
         n_irq++;

   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; the request is held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         errors++;
         conclude();
      end
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Pin outputs follow one clock after a write; leave margin for sampling stages
   task automatic settle;
      repeat (4) @(posedge clock);
   endtask

   initial
   begin
      e3 = {<<{lcd_seg[27:24]}};
      e4 = {<<{lcd_seg[7:0]}};
      e9 = {<<{lcd_seg[23:16]}};
      repeat (2) @(posedge clock);
      chk(p0_oe, 0);
      chk(p2_o, 0);
      resetn <= 1'b1;
      apb(0, ppm_pkg::A_P0_DIR, 0);
      chk(rv, 0);
      // Port 0 in port mode: direction, latch and pull-ups
      apb(1, ppm_pkg::A_P0_DIR, 32'h5);
      apb(1, ppm_pkg::A_P0_DAT, 32'h1);
      apb(1, ppm_pkg::A_P0_PU, 32'hf);
      settle();
      chk(p0_oe, 4'h5);
      chk(p0_o & p0_oe, 4'h1);
      chk(p0_pu, 4'ha);
      apb(0, ppm_pkg::A_P0_DAT, 0);
      chk(rv, 32'hb);
      // Every edge mode on every interrupt input
      p0_den <= 4'hf;
      apb(1, ppm_pkg::A_P0_PU, 0);
      apb(1, ppm_pkg::A_P0_CTL, 32'h7);
      settle();
      chk(p0_oe, 0);
      for (int i = 0; i < 3; i++)
      begin
         for (int m = 1; m < 4; m++)
         begin
            apb(1, ppm_pkg::A_EDGE, 32'(m) << (2 * i));
            sel = i;
            settle();
            n_irq = 0;
            p0_drv[i] <= 1'b1;
            settle();
            chk(p0_alt_i, 4'(1 << i));
            p0_drv[i] <= 1'b0;
            settle();
            chk(32'(n_irq), (m == 3) ? 32'h2 : 32'h1);
         end
      end
      // Port 1 analog selection; its data register ignores writes
      apb(1, ppm_pkg::A_P1_CTL, 32'h15);
      apb(1, ppm_pkg::A_P1_DAT, 0);
      chk(ev, 0);
      settle();
      chk(analog_in_sel, 5'h15);
      apb(0, ppm_pkg::A_P1_DAT, 0);
      chk(rv, 32'h0a);
      // Output-only ports: latch first, then meter outputs
      apb(1, ppm_pkg::A_P2_DAT, 32'ha5);
      apb(1, ppm_pkg::A_P5_DAT, 32'h3c);
      settle();
      chk(p2_o, 8'ha5);
      chk(p5_o, 8'h3c);
      apb(1, ppm_pkg::A_P2_CTL, 32'hff);
      apb(1, ppm_pkg::A_P5_CTL, 32'hff);
      settle();
      chk(p2_o, meter_pwm[7:0]);
      chk(p5_o, meter_pwm[15:8]);
      // Port 3: direction and latch are set before handing pins to the serial unit
      apb(1, ppm_pkg::A_P3_DIR, 32'h3);
      apb(1, ppm_pkg::A_P3_DAT, 32'h1);
      settle();
      chk(p3_oe, 4'h3);
      chk(p3_o & p3_oe, 4'h1);
      apb(1, ppm_pkg::A_P3_CTL, 32'hf);
      apb(1, ppm_pkg::A_P9_DIR, 32'h0f);
      settle();
      chk(p3_o, p3_alt_o);
      chk(p3_oe, p3_alt_oe);
      chk(p3_alt_i & p3_oe, 4'h8);
      chk(p9_oe, 8'h0f);
      apb(1, ppm_pkg::A_P9_CTL, 32'hff);
      apb(1, ppm_pkg::A_SEG_SEL, 32'hfff);
      settle();
      chk(p3_o, e3);
      chk(p9_o, e9);
      chk(p9_oe, 8'hff);
      chk(p3_alt_i, 4'h0);
      apb(1, ppm_pkg::A_SEG_SEL, 0);
      settle();
      chk(p9_o, p9_alt_o);
      chk(p9_oe, p9_alt_oe);
      chk(p9_alt_i & p9_oe, 8'h12);
      // Ports 4 and 8: direction, then whole-byte segment mode
      apb(1, ppm_pkg::A_P4_DIR, 32'h0f);
      apb(1, ppm_pkg::A_P8_DIR, 32'hf0);
      settle();
      chk(p4_oe, 8'h0f);
      chk(p8_oe, 8'hf0);
      apb(1, ppm_pkg::A_P4_CTL, 32'h1);
      apb(1, ppm_pkg::A_P8_CTL, 32'h1);
      settle();
      chk(p4_o, e4);
      chk(p4_oe, 8'hff);
      chk(p8_o, lcd_seg[15:8]);
      chk(p8_oe, 8'hff);
      // Port 6: bit 0 stays a port output, the rest go to peripherals
      apb(1, ppm_pkg::A_P6_DIR, 32'h01);
      apb(1, ppm_pkg::A_P6_DAT, 32'h3f);
      apb(1, ppm_pkg::A_P6_CTL, 32'h3e);
      settle();
      chk(p6_oe, {p6_alt_oe[5:1], 1'b1});
      chk(p6_o, {p6_alt_o[5:1], 1'b1});
      chk(p6_alt_i & p6_oe, 6'h20);
      // Commons drive only with both four-time division and third bias
      for (int c = 1; c < 4; c++)
      begin
         apb(1, ppm_pkg::A_LCD_CFG, 32'(c));
         settle();
         chk(lcd_common_out, (c == 3) ? lcd_common_in : 4'h0);
      end
      // Unmapped address is refused
      apb(1, 8'h70, 32'hff);
      chk(ev, 1'b1);
      apb(0, 8'h70, 0);
      chk(rv, 0);
      // Reset in mid-run releases every pin and clears the registers
      resetn <= 1'b0;
      repeat (2) @(posedge clock);
      chk(p4_oe, 0);
      chk(lcd_common_out, 0);
      resetn <= 1'b1;
      apb(0, ppm_pkg::A_P4_CTL, 0);
      chk(rv, 0);
      conclude();
   end
endmodule
